//--- tb/bslc_host_model.sv
// Behavioural host that writes the serial configuration port.
`timescale 1ns/10ps
module bslc_host_model (
   output logic ser_clk,
   output logic ser_cs_n,
   output logic ser_data
);
   // The serial clock stands still between frames; released data shows the inverse of its last bit.
   initial
   begin
      ser_clk  = 1'b0;
      ser_cs_n = 1'b1;
      ser_data = 1'b0;
   end

   // Sends the low n bits of w, most significant first; the odd start delay keeps the phase unrelated.
   task automatic send(input logic [28:0] w, input int n);
      #13;
      ser_cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         ser_data = w[i];
         #40 ser_clk = 1'b1;
         #40 ser_clk = 1'b0;
      end
      #40 ser_cs_n = 1'b1;
      ser_data = ~ser_data;
      #200;
   endtask
endmodule

//--- tb/bslc_speed_loop_tb_top.sv
// Self-checking bench for the motor speed loop controller.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module bslc_speed_loop_tb_top;
   import bslc_pkg::*;
   localparam int BLK = 20;
   localparam int WDC = 200;
   logic           clk, resetn, ser_clk, ser_cs_n, ser_data, sector_data, thermal_fault, brake_in;
   logic [2:0]     bemf_cmp;
   bslc_drive_type drive;
   logic           err_fast, err_slow, loop_preload, fll_disable, gain_half, reverse, sleep;
   logic           speed_a, diag_out, mon_on, e, pd, pa;
   logic [1:0]     ilim_sel, wd_isel;
   logic [28:0]    w;
   logic [31:0]    seed;
   bslc_cfg_type   cfg;
   int             errors, comparisons, cnt, s, tog;
   logic           exp_q[$];

   bslc_speed_loop #(.BLANK_CYC(BLK), .WD_CYC(WDC)) DUT (
      .clk(clk), .resetn(resetn), .ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data(ser_data),
      .bemf_cmp(bemf_cmp), .sector_data(sector_data), .thermal_fault(thermal_fault), .brake_in(brake_in),
      .drive(drive), .err_fast(err_fast), .err_slow(err_slow), .loop_preload(loop_preload),
      .fll_disable(fll_disable), .gain_half(gain_half), .ilim_sel(ilim_sel),
      .watchdog_timing_cap_isel(wd_isel), .reverse(reverse), .sleep(sleep), .speed_a(speed_a),
      .diag_out(diag_out));

   bslc_host_model host (.ser_clk(ser_clk), .ser_cs_n(ser_cs_n), .ser_data(ser_data));

   // Clock generator.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic results();
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Six cycles after the frame cover the two-flop synchroniser and the latch.
   task automatic load(input bslc_cfg_type c);
      host.send(c, 29);
      cyc(6);
   endtask

   task automatic wait_drive(input int lim);
      bslc_drive_type d0;
      d0 = drive;
      cnt = 0;
      while (drive === d0 && cnt < lim)
      begin
         @(posedge clk);
         cnt++;
      end
      `CHK("drive_moved", 1'b1, cnt < lim)
   endtask

   task automatic chk_cfg(input logic [28:0] x);
      `CHK("gain_half", x[28], gain_half)
      `CHK("ilim_sel", {x[3], x[4]}, ilim_sel)
      `CHK("reverse", x[25], reverse)
      `CHK("fll_disable", x[24], fll_disable)
      `CHK("wd_isel", {x[26], x[27]}, wd_isel)
      `CHK("sleep", ~x[0], sleep)
   endtask

   // One sector pulse; the sync level at the end of the high phase tells whether the window still runs.
   task automatic pulse(input int hi, input logic fast);
      sector_data <= 1'b1;
      cyc(hi);
      `CHK("sync", fast, diag_out)
      exp_q.push_back(fast);
      sector_data <= 1'b0;
      cyc(hi);
   endtask

   // Error pulses are matched against the oldest noted expectation; error pulses outside speed tests are ignored.
   always @(posedge clk)
      if (mon_on && (err_fast === 1'b1 || err_slow === 1'b1))
      begin
         if (exp_q.size() == 0)
         begin
            errors++;
            $display("[ERR] err_pulse expected none seen %b%b", err_fast, err_slow);
         end
         else
         begin
            e = exp_q.pop_front();
            `CHK("err_pair", {e, ~e}, {err_fast, err_slow})
         end
      end

   // A hang is cut short well beyond the expected run length.
   initial
   begin
      #400000;
      errors++;
      $display("[ERR] run expected done seen timeout");
      results();
   end

   // Main sequence.
   initial
   begin
      resetn = 1'b0;
      sector_data = 1'b0;
      thermal_fault = 1'b0;
      brake_in = 1'b0;
      bemf_cmp = 3'h0;
      mon_on = 1'b0;
      seed = 32'h961d2439;
      cyc(16);
      resetn <= 1'b1;
      cyc(2);
      `CHK("sleep", 1'b1, sleep)
      `CHK("loop_preload", 1'b1, loop_preload)
      `CHK("diag_out", 1'b0, diag_out)
      `CHK("drive", 6'h00, drive)
      // Random words, the last all ones, then a short word that must clear the upper bits.
      for (int k = 0; k < 4; k++)
      begin
         seed = lfsr(seed);
         w = (k == 3) ? 29'h1fffffff : seed[28:0];
         load(w);
         chk_cfg(w);
      end
      host.send(29'h15a, 10);
      cyc(6);
      chk_cfg(29'h15a);
      // Speed loop in sector mode; the source changes only while sync is low.
      cfg = '0;
      cfg.speed_n = 14'h3ffc;
      {cfg.mux_hi, cfg.mux_lo} = MUX_SYNC;
      load(cfg);
      `CHK("sync_idle", 1'b0, diag_out)
      cfg.sector_mode = 1'b1;
      cfg.run = 1'b1;
      load(cfg);
      `CHK("preload_start", 1'b1, loop_preload)
      mon_on <= 1'b1;
      pulse(40, 1'b1);
      `CHK("preload_drop", 1'b0, loop_preload)
      pulse(60, 1'b0);
      cyc(4);
      mon_on <= 1'b0;
      `CHK("err_left", 0, exp_q.size())
      cfg.ext_speed = 1'b1;
      load(cfg);
      `CHK("preload_ext", 1'b1, loop_preload)
      `CHK("fll_disable", 1'b1, fll_disable)
      // Speed_a and thermal selections of the diagnostic output, both levels each.
      for (int m = 0; m < 2; m++)
      begin
         {cfg.mux_hi, cfg.mux_lo} = m ? MUX_THERM : MUX_SPEED_A;
         load(cfg);
         for (int v = 0; v < 2; v++)
         begin
            if (m == 1)
               thermal_fault <= v[0];
            else
               sector_data <= v[0];
            cyc(8);
            `CHK("diag_out", v[0], diag_out)
         end
         sector_data <= 1'b0;
         thermal_fault <= 1'b0;
      end
      // Forced commutation with no valid crossing, in both directions.
      for (int rv = 0; rv < 2; rv++)
      begin
         cfg = '0;
         cfg.reverse = rv[0];
         load(cfg);
         cfg.run = 1'b1;
         load(cfg);
         `CHK("drive_s1", 6'h0c, drive)
         wait_drive(WDC + 50);
         if (rv == 0)
            `CHK("wd_late", 1'b1, cnt > WDC - 40)
         `CHK("drive_next", (rv == 1) ? 6'h14 : 6'h0a, drive)
      end
      brake_in <= 1'b1;
      cyc(6);
      `CHK("brake_drive", 6'h07, drive)
      brake_in <= 1'b0;
      // Internal speed_a: four poles give one speed_a toggle per twelve crossings.
      cfg = '0;
      cfg.pole_lo = 1'b1;
      {cfg.mux_hi, cfg.mux_lo} = MUX_ZC;
      load(cfg);
      cfg.run = 1'b1;
      load(cfg);
      s = 0;
      tog = 0;
      pa = speed_a;
      for (int k = 0; k < 24; k++)
      begin
         // A crossing inside the blanking time is ignored, so each state first runs past it.
         cyc(BLK + 8);
         pd = diag_out;
         bemf_cmp <= {3{~s[0]}};
         wait_drive(BLK + 40);
         s = (s == 5) ? 0 : s + 1;
         cyc(4);
         `CHK("zc_toggle", ~pd, diag_out)
         if (speed_a !== pa)
            tog++;
         pa = speed_a;
      end
      `CHK("speed_a_toggles", 2, tog)
      results();
   end
endmodule

//--- verilog/bslc_pkg.sv
// Shared constants and types for the motor speed loop controller.
package bslc_pkg;

   // Serial configuration word.
   localparam int WORD_W  = 29;
   localparam int SPEED_W = 14;
   localparam int REF_W   = 18;
   localparam int TOG_W   = 6;
   localparam int TIM_W   = 17;

   // Oscillator rate and the base blanking and watchdog times at the lowest charge current.
   localparam int CLK_MHZ  = 50;
   localparam int BLANK_US = 100;
   localparam int WD_US    = 2000;

   // Diagnostic multiplexer selections, written {D22,D23}.
   localparam logic [1:0] MUX_SPEED_A  = 2'h0;
   localparam logic [1:0] MUX_THERM = 2'h1;
   localparam logic [1:0] MUX_SYNC  = 2'h2;
   localparam logic [1:0] MUX_ZC    = 2'h3;

   // Zero-cross toggles per mechanical revolution (poles times three), selected by {D20,D21}.
   localparam logic [TOG_W-1:0] TOG_8P  = 6'h18;
   localparam logic [TOG_W-1:0] TOG_4P  = 6'h0c;
   localparam logic [TOG_W-1:0] TOG_16P = 6'h30;
   localparam logic [TOG_W-1:0] TOG_12P = 6'h24;

   // Configuration word, D28 in the most significant position down to D0.
   typedef struct packed {
      logic                gain_half;
      logic                wdc_lo;
      logic                wdc_hi;
      logic                reverse;
      logic                ext_speed;
      logic                mux_lo;
      logic                mux_hi;
      logic                pole_lo;
      logic                pole_hi;
      logic                sector_mode;
      logic [SPEED_W-1:0]  speed_n;
      logic                ilim_lo;
      logic                ilim_hi;
      logic                brake;
      logic                step;
      logic                run;
   } bslc_cfg_type;

   // All bits low after reset: sleep mode and the slowest speed reference.
   localparam bslc_cfg_type CFG_RESET = '0;

   // Six commutation states, state 1 encoded as zero.
   typedef enum logic [2:0] {
      SEQ_S1 = 3'b000,
      SEQ_S2 = 3'b001,
      SEQ_S3 = 3'b010,
      SEQ_S4 = 3'b011,
      SEQ_S5 = 3'b100,
      SEQ_S6 = 3'b101
   } bslc_seq_type;

   // Half-bridge drive, bit 0 is phase A, bit 2 is phase C.
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } bslc_drive_type;

endpackage

//--- verilog/bslc_speed_loop.sv
// Sequencer, watchdog, frequency-locked speed loop, diagnostics and serial port of the motor controller.
// What this block does
// - Force commutation when watchdog expires without crossing.
// - Speed_a from back-EMF or external pulse input.
// - Desired speed held as 14-bit value.
// - Zero-cross toggle flips at every valid crossing.
// - Pole count taken from bits D20, D21.
// - Pole codes 00=8, 01=4, 10=16, 11=12.
// - Internal speed_a toggles once per revolution, starts reference.
// - Reference length is sum of selected weights.
// - Speed bits active low, weights 16 to 131072.
// - Early speed_a fall is fast, late is slow.
// - D24 high disables the frequency-locked loop.
// - Current clamp selected by D3 and D4.
// - D19 high selects the external speed_a pulse.
// - Diagnostic mux driven by D22 and D23.
// - Mux codes 00 speed_a, 01 thermal, 10 sync, 11 toggle.
// - Thermal selection shows low normal, high tripped.
// - Preload at start, released by first fast error.
// - Preload also held while external speed selected.
// - Default speed setting is the slowest.
// - Direction taken from bit D25.
// - Low is forward, high is reverse.
// - Word shifted MSB first on rising serial clock.
// - Chip select rising latches the word as configuration.
// - Short words leave unwritten upper bits zero.
`timescale 1ns/10ps
module bslc_speed_loop #(
   parameter int BLANK_CYC = bslc_pkg::BLANK_US * bslc_pkg::CLK_MHZ,
   parameter int WD_CYC    = bslc_pkg::WD_US * bslc_pkg::CLK_MHZ
) (
   input  wire logic                     clk,
   input  wire logic                     resetn,
   input  wire logic                     ser_clk,
   input  wire logic                     ser_cs_n,
   input  wire logic                     ser_data,
   input  wire logic [2:0]               bemf_cmp,
   input  wire logic                     sector_data,
   input  wire logic                     thermal_fault,
   input  wire logic                     brake_in,
   output bslc_pkg::bslc_drive_type      drive,
   output logic                          err_fast,
   output logic                          err_slow,
   output logic                          loop_preload,
   output logic                          fll_disable,
   output logic                          gain_half,
   output logic [1:0]                    ilim_sel,
   output logic [1:0]                    watchdog_timing_cap_isel,
   output logic                          reverse,
   output logic                          sleep,
   output logic                          speed_a,
   output logic                          diag_out
);
   import bslc_pkg::*;

   // Blanking or watchdog length shrinks as the charge current setting rises.
   function automatic logic [TIM_W-1:0] scale_time(input int base, input logic [1:0] sel);
      int t;
      t = base / (int'(sel) + 1);
      if (t < 2)
      begin
         t = 2;
      end
      return t[TIM_W-1:0];
   endfunction

   // Phase left floating in each state, where back-EMF is watched.
   function automatic logic [1:0] float_phase(input bslc_seq_type s);
      case (s)
         SEQ_S1, SEQ_S4: return 2'h1;
         SEQ_S2, SEQ_S5: return 2'h2;
         default:        return 2'h0;
      endcase
   endfunction

   // Drive pattern of each state.
   function automatic bslc_drive_type drive_of(input bslc_seq_type s);
      case (s)
         SEQ_S1:  return '{hi: 3'h1, lo: 3'h4};
         SEQ_S2:  return '{hi: 3'h1, lo: 3'h2};
         SEQ_S3:  return '{hi: 3'h4, lo: 3'h2};
         SEQ_S4:  return '{hi: 3'h4, lo: 3'h1};
         SEQ_S5:  return '{hi: 3'h2, lo: 3'h1};
         default: return '{hi: 3'h2, lo: 3'h4};
      endcase
   endfunction

   logic [WORD_W-1:0]  sr_r;
   logic               fresh_r;
   logic [2:0]         cs_sync_r;
   bslc_cfg_type       cfg_r;
   logic [5:0]         pin_s1_r;
   logic [5:0]         pin_s2_r;
   bslc_seq_type       seq_r;
   logic [TIM_W-1:0]   tim_r;
   logic               cmp_prev_r;
   logic               zc_r;
   logic [TOG_W-1:0]   tog_cnt_r;
   logic               speed_a_int_r;
   logic               speed_a_r;
   logic [REF_W-1:0]   ref_cnt_r;
   logic               err_fast_r;
   logic               err_slow_r;
   logic               preload_r;
   bslc_drive_type     drive_r;
   logic               diag_r;

   logic [2:0]         bemf_s;
   logic               sector_s;
   logic               therm_s;
   logic               brake_s;
   logic               running;
   logic [TIM_W-1:0]   blank_lim;
   logic [TIM_W-1:0]   wd_lim;
   logic               cmp_now;
   logic               cross_ok;
   logic               wd_expire;
   logic               commutate;
   bslc_seq_type       seq_nxt;
   logic [TOG_W-1:0]   pole_tog;
   logic               speed_a_nxt;
   logic               speed_a_edge;
   logic               speed_a_fall;
   logic [REF_W-1:0]   ref_total;
   logic               fll_on;
   logic               cs_rise;

   // Serial side: an idle chip select marks the next bit as the first of a new word.
   always_ff @(posedge ser_clk or posedge ser_cs_n)
   begin
      if (ser_cs_n)
      begin
         fresh_r <= 1'b1;
      end
      else
      begin
         fresh_r <= 1'b0;
      end
   end

   // Shift register on the host clock; it only moves while chip select is low.
   always_ff @(posedge ser_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sr_r <= '0;
      end
      else if (!ser_cs_n)
      begin
         if (fresh_r)
         begin
            sr_r <= {{(WORD_W-1){1'b0}}, ser_data};
         end
         else
         begin
            sr_r <= {sr_r[WORD_W-2:0], ser_data};
         end
      end
   end

   // Chip select is the handshake: the word is quiet whenever chip select is high, so one
   // synchronised level edge is enough to take it over safely.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cs_sync_r <= 3'h7;
      end
      else
      begin
         cs_sync_r <= {cs_sync_r[1:0], ser_cs_n};
      end
   end

   assign cs_rise = cs_sync_r[1] & ~cs_sync_r[2];

   // Active configuration, cleared by reset to sleep and the slowest speed.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg_r <= CFG_RESET;
      end
      else if (cs_rise)
      begin
         cfg_r <= bslc_cfg_type'(sr_r);
      end
   end

   // Pin inputs pass two flip-flops before any logic reads them.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end
      else
      begin
         pin_s1_r <= {brake_in, thermal_fault, sector_data, bemf_cmp};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign bemf_s   = pin_s2_r[2:0];
   assign sector_s = pin_s2_r[3];
   assign therm_s  = pin_s2_r[4];
   assign brake_s  = pin_s2_r[5];

   // Commutation timing and back-EMF qualification.
   assign running   = cfg_r.run & ~cfg_r.brake & ~brake_s;
   assign blank_lim = scale_time(BLANK_CYC, {cfg_r.wdc_hi, cfg_r.wdc_lo});
   assign wd_lim    = scale_time(WD_CYC, {cfg_r.wdc_hi, cfg_r.wdc_lo});
   assign cmp_now   = bemf_s[float_phase(seq_r)];
   assign cross_ok  = running & ~cfg_r.step & (tim_r >= blank_lim) & (cmp_now != cmp_prev_r)
                      & (cmp_now == (~seq_r[0] ^ cfg_r.reverse));
   assign wd_expire = running & (tim_r == wd_lim - 1'b1);
   assign commutate = cross_ok | wd_expire;

   // Next state steps up for forward and down for reverse.
   always_comb
   begin
      if (!cfg_r.reverse)
      begin
         seq_nxt = (seq_r == SEQ_S6) ? SEQ_S1 : bslc_seq_type'(seq_r + 3'h1);
      end
      else
      begin
         seq_nxt = (seq_r == SEQ_S1) ? SEQ_S6 : bslc_seq_type'(seq_r - 3'h1);
      end
   end

   // Sequencer; a missing crossing keeps forcing steps until back-EMF locks in again.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         seq_r      <= SEQ_S1;
         tim_r      <= '0;
         cmp_prev_r <= 1'b0;
      end
      else
      begin
         cmp_prev_r <= cmp_now;
         if (!running)
         begin
            seq_r <= SEQ_S1;
            tim_r <= '0;
         end
         else if (commutate)
         begin
            seq_r <= seq_nxt;
            tim_r <= '0;
         end
         else
         begin
            tim_r <= tim_r + 1'b1;
         end
      end
   end

   // Zero-cross toggle and the once-around count.
   always_comb
   begin
      case ({cfg_r.pole_hi, cfg_r.pole_lo})
         2'h0:    pole_tog = TOG_8P;
         2'h1:    pole_tog = TOG_4P;
         2'h2:    pole_tog = TOG_16P;
         default: pole_tog = TOG_12P;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         zc_r       <= 1'b0;
         tog_cnt_r  <= '0;
         speed_a_int_r <= 1'b0;
      end
      else if (cross_ok)
      begin
         zc_r <= ~zc_r;
         if (tog_cnt_r >= pole_tog - 1'b1)
         begin
            tog_cnt_r  <= '0;
            speed_a_int_r <= ~speed_a_int_r;
         end
         else
         begin
            tog_cnt_r <= tog_cnt_r + 1'b1;
         end
      end
   end

   // Speed_a source; switching sources is only clean while the reference is idle.
   assign speed_a_nxt = cfg_r.sector_mode ? sector_s : speed_a_int_r;
   assign speed_a_edge   = speed_a_nxt != speed_a_r;
   assign speed_a_fall   = speed_a_r & ~speed_a_nxt;
   assign ref_total   = {~cfg_r.speed_n, 4'h0};
   assign fll_on      = cfg_r.run & ~cfg_r.ext_speed;

   // Reference window restarts on every speed_a edge; a fall decides fast or slow first.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         speed_a_r  <= 1'b0;
         ref_cnt_r  <= '0;
         err_fast_r <= 1'b0;
         err_slow_r <= 1'b0;
      end
      else
      begin
         speed_a_r  <= speed_a_nxt;
         err_fast_r <= fll_on & speed_a_fall & (ref_cnt_r != '0);
         err_slow_r <= fll_on & speed_a_fall & (ref_cnt_r == '0);
         if (speed_a_edge)
         begin
            ref_cnt_r <= ref_total;
         end
         else if (ref_cnt_r != '0)
         begin
            ref_cnt_r <= ref_cnt_r - 1'b1;
         end
      end
   end

   // Preload holds the filter at threshold until the motor first runs too fast.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         preload_r <= 1'b1;
      end
      else if (!cfg_r.run || cfg_r.ext_speed)
      begin
         preload_r <= 1'b1;
      end
      else if (err_fast_r)
      begin
         preload_r <= 1'b0;
      end
   end

   // Output drive and diagnostic multiplexer.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         drive_r <= '0;
         diag_r  <= 1'b0;
      end
      else
      begin
         if (cfg_r.brake || brake_s)
         begin
            drive_r <= '{hi: 3'h0, lo: 3'h7};
         end
         else if (!cfg_r.run)
         begin
            drive_r <= '0;
         end
         else
         begin
            drive_r <= drive_of(seq_r);
         end
         case ({cfg_r.mux_hi, cfg_r.mux_lo})
            MUX_SPEED_A:  diag_r <= speed_a_r;
            MUX_THERM: diag_r <= therm_s;
            MUX_SYNC:  diag_r <= ref_cnt_r != '0;
            MUX_ZC:    diag_r <= zc_r;
            default:   diag_r <= 1'b0;
         endcase
      end
   end

   // Configuration fields go straight out of the configuration register.
   assign drive                    = drive_r;
   assign err_fast                 = err_fast_r;
   assign err_slow                 = err_slow_r;
   assign loop_preload             = preload_r;
   assign fll_disable              = cfg_r.ext_speed;
   assign gain_half                = cfg_r.gain_half;
   assign ilim_sel                 = {cfg_r.ilim_hi, cfg_r.ilim_lo};
   assign watchdog_timing_cap_isel = {cfg_r.wdc_hi, cfg_r.wdc_lo};
   assign reverse                  = cfg_r.reverse;
   assign sleep                    = ~cfg_r.run;
   assign speed_a                  = speed_a_r;
   assign diag_out                 = diag_r;

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_wd_force;
      wd_expire && !cross_ok |=> seq_r == $past(seq_nxt) && tim_r == '0;
   endproperty
   a_wd_force: assert property (p_wd_force) else $error("watchdog expiry did not force a step");

   property p_zc_toggle;
      cross_ok |=> zc_r != $past(zc_r);
   endproperty
   a_zc_toggle: assert property (p_zc_toggle) else $error("zero-cross toggle missed a crossing");

   property p_speed_a_rev;
      cross_ok && !cfg_r.sector_mode && tog_cnt_r == pole_tog - 1'b1 ##1 !cfg_r.sector_mode
         |-> ##1 speed_a_r != $past(speed_a_r, 2);
   endproperty
   a_speed_a_rev: assert property (p_speed_a_rev) else $error("speed_a did not flip after a full revolution");

   property p_ref_load;
      speed_a_edge |=> ref_cnt_r == $past(ref_total);
   endproperty
   a_ref_load: assert property (p_ref_load) else $error("reference not loaded on speed_a edge");

   property p_err_fast;
      fll_on && speed_a_fall && ref_cnt_r != '0 |=> err_fast_r && !err_slow_r;
   endproperty
   a_err_fast: assert property (p_err_fast) else $error("early speed_a fall gave no fast error");

   property p_err_slow;
      fll_on && speed_a_fall && ref_cnt_r == '0 |=> err_slow_r && !err_fast_r;
   endproperty
   a_err_slow: assert property (p_err_slow) else $error("late speed_a fall gave no slow error");

   property p_fll_off;
      cfg_r.ext_speed |=> !err_fast_r && !err_slow_r;
   endproperty
   a_fll_off: assert property (p_fll_off) else $error("speed error while loop disabled");

   property p_preload_release;
      err_fast_r && cfg_r.run && !cfg_r.ext_speed |=> !loop_preload;
   endproperty
   a_preload_release: assert property (p_preload_release) else $error("fast error did not release preload");

   property p_preload_ext;
      cfg_r.ext_speed |=> loop_preload;
   endproperty
   a_preload_ext: assert property (p_preload_ext) else $error("preload not held in external speed mode");

   property p_diag_therm;
      {cfg_r.mux_hi, cfg_r.mux_lo} == MUX_THERM |=> diag_out == $past(therm_s);
   endproperty
   a_diag_therm: assert property (p_diag_therm) else $error("diagnostic output does not show thermal state");

   property p_latch;
      cs_rise |=> cfg_r == $past(sr_r);
   endproperty
   a_latch: assert property (p_latch) else $error("word not latched at chip select rise");

   property p_first_bit;
      @(posedge ser_clk) disable iff (!resetn)
      !ser_cs_n && fresh_r |=> sr_r[WORD_W-1:1] == '0;
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("upper bits not cleared at word start");

endmodule
